// *** shared/hrp_params.svh ***
// constants of the host readback port: port addresses, read codes, status layout
// assumes it is included by hrp_pkg and the design files only
`ifndef HRP_PARAMS_SVH
`define HRP_PARAMS_SVH

// ----------------------------------------
// port addresses on host_addr
// ----------------------------------------
`define HRP_ADDR_READ_SEL 3'h5
`define HRP_ADDR_GAIN_SAMPLE 3'h2
`define HRP_ADDR_STATUS 3'h7

// ----------------------------------------
// read codes
// ----------------------------------------
`define HRP_CODE_IQ 3'h0
`define HRP_CODE_MAG_PHASE 3'h1
`define HRP_CODE_FREQ 3'h2
`define HRP_CODE_LEVEL 3'h4
`define HRP_CODE_GAIN_TIMING 3'h5

// ----------------------------------------
// read addresses within a source
// ----------------------------------------
`define HRP_RA_BYTE0 3'h0
`define HRP_RA_BYTE1 3'h1
`define HRP_RA_BYTE2 3'h2
`define HRP_RA_BYTE3 3'h3

// ----------------------------------------
// status byte field positions
// ----------------------------------------
`define HRP_ST_DEPTH_LSB 4
`define HRP_ST_EMPTY_BIT 3
`define HRP_ST_FULL_BIT 2
`define HRP_ST_READY_N_BIT 1
`define HRP_ST_LEVEL_DONE_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define HRP_RST_CODE 3'h0
`define HRP_RST_BYTE 8'h00
`define HRP_RST_GAIN 15'h0000
`define HRP_RST_STROBE_N 1'b1

`endif

// *** shared/hrp_pkg.sv ***
// types of the host readback port
// assumes hrp_params.svh is on the include path
`include "hrp_params.svh"

package hrp_pkg;

	// ----------------------------------------
	// read source selection
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		HRP_SRC_IQ = `HRP_CODE_IQ,
		HRP_SRC_MAG_PHASE = `HRP_CODE_MAG_PHASE,
		HRP_SRC_FREQ = `HRP_CODE_FREQ,
		HRP_SRC_UNUSED3 = 3'h3,
		HRP_SRC_LEVEL = `HRP_CODE_LEVEL,
		HRP_SRC_GAIN_TIMING = `HRP_CODE_GAIN_TIMING,
		HRP_SRC_UNUSED6 = 3'h6,
		HRP_SRC_UNUSED7 = 3'h7
	} hrp_read_code_t;

	typedef logic [7:0] hrp_byte_t;

endpackage : hrp_pkg

// *** shared/hrp_strobe_if.sv ***
// carries synchronised host strobe events from the pin stage to the port logic
// assumes one clock; all members are on clk_i
`timescale 1ns/1ps

interface hrp_strobe_if;
	logic write_done;
	logic read_start;
	logic read_low;
	logic [2:0] addr;
	logic [7:0] data;

	modport pins
	(
		output write_done,
		output read_start,
		output read_low,
		output addr,
		output data
	);

	modport port
	(
		input write_done,
		input read_start,
		input read_low,
		input addr,
		input data
	);
endinterface : hrp_strobe_if

// *** rtl/hrp_pin_sync.sv ***
// two-flop synchronisers and edge detection for the host port pins
// assumes the host holds address and data steady around its strobe edges
`timescale 1ns/1ps
`include "hrp_params.svh"

module hrp_pin_sync
	import hrp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] host_addr_i,
	input wire logic [7:0] host_data_i,
	input wire logic write_strobe_n_i,
	input wire logic read_strobe_n_i,
	hrp_strobe_if.pins sb
);
	// ----------------------------------------
	// synchroniser state
	// ----------------------------------------
	logic [12:0] meta_q;
	logic [12:0] meta_d;
	logic [12:0] sync_q;
	logic [12:0] sync_d;
	logic wr_n_old_q;
	logic wr_n_old_d;
	logic rd_n_old_q;
	logic rd_n_old_d;

	always_comb
	begin
		meta_d = {write_strobe_n_i, read_strobe_n_i, host_addr_i, host_data_i};
		sync_d = meta_q;
		wr_n_old_d = sync_q[12];
		rd_n_old_d = sync_q[11];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= {`HRP_RST_STROBE_N, `HRP_RST_STROBE_N, 3'h0, `HRP_RST_BYTE};
			sync_q <= {`HRP_RST_STROBE_N, `HRP_RST_STROBE_N, 3'h0, `HRP_RST_BYTE};
			wr_n_old_q <= `HRP_RST_STROBE_N;
			rd_n_old_q <= `HRP_RST_STROBE_N;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			wr_n_old_q <= wr_n_old_d;
			rd_n_old_q <= rd_n_old_d;
		end
	end

	// edges are seen on the synchronised copy only, never on the first flop
	assign sb.write_done = sync_q[12] & ~wr_n_old_q;
	assign sb.read_start = ~sync_q[11] & rd_n_old_q;
	assign sb.read_low = ~sync_q[11];
	assign sb.addr = sync_q[10:8];
	assign sb.data = sync_q[7:0];

endmodule : hrp_pin_sync

// *** rtl/hrp_host_readback_port.sv ***
// readback half of the host microprocessor port: read code, byte select, status
// assumes host pins are asynchronous; internal sources are on clk_i
`timescale 1ns/1ps
`include "hrp_params.svh"

// What this block does
// - write to address 5 stores data bits 2:0 as read code
// - read address on host_addr picks the byte of the selected source
// - selected byte is driven from the falling read strobe onward
// - read address 111 returns status regardless of read code
// - codes 000, 001, 010 map I/Q, magnitude/phase, frequency bytes
// - code 100 returns 24-bit level detector bytes at 000 to 010
// - gain value is sampled for readback only by a write to location 10
// - gain bytes: low mantissa, then shift bits and top mantissa bits
// - code 101 addresses 010, 011 return unstabilised timing error bytes
// - status bits 6:4 show FIFO fill depth
// - status bit 3 shows FIFO empty
// - status bit 2 shows FIFO full; new samples refused while full
// - status bit 1 is the active-low buffer ready flag
// - status bit 0 shows level detector level_done_a done
// - address and data are captured on the rising write strobe
// - address 5 is decoded apart from holding and destination locations

module hrp_host_readback_port
	import hrp_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int LEVEL_W = 24,
	parameter int MANT_W = 11,
	parameter int SHIFT_W = 4
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] host_addr_i,
	input wire logic [7:0] host_data_i,
	input wire logic write_strobe_n_i,
	input wire logic read_strobe_n_i,
	output logic [7:0] host_data_o,
	output logic host_data_oe_n_o,
	input wire logic [DATA_W-1:0] i_data_i,
	input wire logic [DATA_W-1:0] q_data_i,
	input wire logic [DATA_W-1:0] mag_data_i,
	input wire logic [DATA_W-1:0] phase_data_i,
	input wire logic [DATA_W-1:0] freq_data_i,
	input wire logic [LEVEL_W-1:0] level_data_i,
	input wire logic [MANT_W-1:0] gain_mant_i,
	input wire logic [SHIFT_W-1:0] gain_shift_i,
	input wire logic [DATA_W-1:0] timing_err_i,
	input wire logic [2:0] fifo_depth_i,
	input wire logic fifo_empty_i,
	input wire logic fifo_full_i,
	input wire logic buffer_ready_n_i,
	input wire logic level_done_a_i,
	input wire logic sample_push_i,
	output logic sample_accept_o
);
	// ----------------------------------------
	// pin stage
	// ----------------------------------------
	hrp_strobe_if sb ();

	hrp_pin_sync u_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.host_addr_i(host_addr_i),
		.host_data_i(host_data_i),
		.write_strobe_n_i(write_strobe_n_i),
		.read_strobe_n_i(read_strobe_n_i),
		.sb(sb)
	);

	// ----------------------------------------
	// write side: read code and gain sample
	// ----------------------------------------
	hrp_read_code_t code_q;
	hrp_read_code_t code_d;
	logic [MANT_W+SHIFT_W-1:0] gain_q;
	logic [MANT_W+SHIFT_W-1:0] gain_d;

	always_comb
	begin
		code_d = code_q;
		gain_d = gain_q;
		if (sb.write_done)
		begin
			// only address 5 touches the read code; 0-4 belong to the loader
			if (sb.addr == `HRP_ADDR_READ_SEL)
			begin
				code_d = hrp_read_code_t'(sb.data[2:0]);
			end
			// gain is frozen here so its two bytes always come from one value
			if (sb.addr == `HRP_ADDR_GAIN_SAMPLE)
			begin
				gain_d = {gain_shift_i, gain_mant_i};
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			code_q <= hrp_read_code_t'(`HRP_RST_CODE);
			gain_q <= `HRP_RST_GAIN;
		end
		else
		begin
			code_q <= code_d;
			gain_q <= gain_d;
		end
	end

	// ----------------------------------------
	// read side: byte selection
	// ----------------------------------------
	hrp_byte_t status_byte;
	hrp_byte_t sel_byte;
	logic [MANT_W+SHIFT_W-1:0] gain_wide;

	always_comb
	begin
		status_byte = `HRP_RST_BYTE;
		status_byte[`HRP_ST_DEPTH_LSB +: 3] = fifo_depth_i;
		status_byte[`HRP_ST_EMPTY_BIT] = fifo_empty_i;
		status_byte[`HRP_ST_FULL_BIT] = fifo_full_i;
		status_byte[`HRP_ST_READY_N_BIT] = buffer_ready_n_i;
		status_byte[`HRP_ST_LEVEL_DONE_BIT] = level_done_a_i;
		gain_wide = gain_q;
		sel_byte = `HRP_RST_BYTE;
		if (sb.addr == `HRP_ADDR_STATUS)
		begin
			sel_byte = status_byte;
		end
		else
		begin
			unique case (code_q)
				HRP_SRC_IQ:
				begin
					unique case (sb.addr)
						`HRP_RA_BYTE0: sel_byte = i_data_i[7:0];
						`HRP_RA_BYTE1: sel_byte = i_data_i[15:8];
						`HRP_RA_BYTE2: sel_byte = q_data_i[7:0];
						`HRP_RA_BYTE3: sel_byte = q_data_i[15:8];
						default: sel_byte = `HRP_RST_BYTE;
					endcase
				end
				HRP_SRC_MAG_PHASE:
				begin
					unique case (sb.addr)
						`HRP_RA_BYTE0: sel_byte = mag_data_i[7:0];
						`HRP_RA_BYTE1: sel_byte = mag_data_i[15:8];
						`HRP_RA_BYTE2: sel_byte = phase_data_i[7:0];
						`HRP_RA_BYTE3: sel_byte = phase_data_i[15:8];
						default: sel_byte = `HRP_RST_BYTE;
					endcase
				end
				HRP_SRC_FREQ:
				begin
					unique case (sb.addr)
						`HRP_RA_BYTE0: sel_byte = freq_data_i[7:0];
						`HRP_RA_BYTE1: sel_byte = freq_data_i[15:8];
						default: sel_byte = `HRP_RST_BYTE;
					endcase
				end
				HRP_SRC_LEVEL:
				begin
					unique case (sb.addr)
						`HRP_RA_BYTE0: sel_byte = level_data_i[7:0];
						`HRP_RA_BYTE1: sel_byte = level_data_i[15:8];
						`HRP_RA_BYTE2: sel_byte = level_data_i[23:16];
						default: sel_byte = `HRP_RST_BYTE;
					endcase
				end
				HRP_SRC_GAIN_TIMING:
				begin
					unique case (sb.addr)
						`HRP_RA_BYTE0: sel_byte = gain_wide[7:0];
						`HRP_RA_BYTE1: sel_byte = {1'b0, gain_wide[14:8]};
						// timing error is live, so its two bytes may not match
						`HRP_RA_BYTE2: sel_byte = timing_err_i[7:0];
						`HRP_RA_BYTE3: sel_byte = timing_err_i[15:8];
						default: sel_byte = `HRP_RST_BYTE;
					endcase
				end
				default: sel_byte = `HRP_RST_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// output drive
	// ----------------------------------------
	hrp_byte_t data_q;
	hrp_byte_t data_d;
	logic oe_n_q;
	logic oe_n_d;
	logic accept_q;
	logic accept_d;

	always_comb
	begin
		data_d = data_q;
		// byte is latched at the strobe edge so it stays put for the whole read
		if (sb.read_start)
		begin
			data_d = sel_byte;
		end
		oe_n_d = ~(sb.read_low | sb.read_start);
		accept_d = sample_push_i & ~fifo_full_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_q <= `HRP_RST_BYTE;
			oe_n_q <= `HRP_RST_STROBE_N;
			accept_q <= 1'b0;
		end
		else
		begin
			data_q <= data_d;
			oe_n_q <= oe_n_d;
			accept_q <= accept_d;
		end
	end

	assign host_data_o = data_q;
	assign host_data_oe_n_o = oe_n_q;
	assign sample_accept_o = accept_q;

endmodule : hrp_host_readback_port

// *** dv/hrp_assertions.sv ***
// assertions on the host readback port pins
// assumes a bind by name onto the top module
`timescale 1ns/1ps
module hrp_checker
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] host_addr_i,
	input wire logic read_strobe_n_i,
	input wire logic [7:0] host_data_o,
	input wire logic host_data_oe_n_o,
	input wire logic [2:0] fifo_depth_i,
	input wire logic fifo_empty_i,
	input wire logic fifo_full_i,
	input wire logic buffer_ready_n_i,
	input wire logic level_done_a_i,
	input wire logic sample_push_i,
	input wire logic sample_accept_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reset_idle_a: assert property (disable iff (1'b0)
		rst_i |=> host_data_oe_n_o && host_data_o == 8'h00 && !sample_accept_o)
		else $error("bus or accept active after reset");
	drive_start_a: assert property (
		$fell(read_strobe_n_i) |-> host_data_oe_n_o ##[1:4] !host_data_oe_n_o)
		else $error("bus not driven after read strobe fall");
	drive_hold_a: assert property (
		(read_strobe_n_i == 1'b0) [*6] |-> !host_data_oe_n_o)
		else $error("bus not driven during read");
	data_steady_a: assert property (
		(!read_strobe_n_i && !host_data_oe_n_o) ##1 !read_strobe_n_i |-> $stable(host_data_o))
		else $error("read byte changed mid read");
	bus_release_a: assert property (
		$rose(read_strobe_n_i) |-> ##[1:5] host_data_oe_n_o)
		else $error("bus not released");
	status_byte_a: assert property (
		(!read_strobe_n_i && host_addr_i == 3'h7) [*6] |-> host_data_o ==
		{1'b0, fifo_depth_i, fifo_empty_i, fifo_full_i, buffer_ready_n_i, level_done_a_i})
		else $error("status byte wrong");
	accept_follow_a: assert property (
		!$past(rst_i) |-> sample_accept_o == $past(sample_push_i && !fifo_full_i))
		else $error("accept does not follow push");
	full_refuse_a: assert property (
		fifo_full_i |=> !sample_accept_o)
		else $error("sample accepted while full");
	cover property (!read_strobe_n_i && host_addr_i == 3'h7 ##4 !host_data_oe_n_o);
	cover property (sample_push_i && fifo_full_i);
	cover property (sample_push_i && !fifo_full_i ##1 sample_accept_o);
endmodule : hrp_checker

// *** dv/hrp_host_model.sv ***
// host processor model driving the port pins
// assumes the device drives the bus only while its enable is low
`timescale 1ns/1ps
module hrp_host_model
(
	input wire logic clk_i,
	input wire logic [7:0] host_data_o,
	input wire logic host_data_oe_n_o,
	output logic [2:0] host_addr_i,
	output logic [7:0] host_data_i,
	output logic write_strobe_n_i,
	output logic read_strobe_n_i
);
	logic [7:0] wd = 8'h00;
	logic wen = 1'b0;
	// a floating bus shows inverted stale data so a missing drive cannot pass
	assign host_data_i = wen ? wd : (host_data_oe_n_o ? ~wd : host_data_o);
	initial
	begin
		host_addr_i = 3'h0;
		write_strobe_n_i = 1'b1;
		read_strobe_n_i = 1'b1;
	end
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		host_addr_i = a;
		wd = d;
		wen = 1'b1;
		write_strobe_n_i = 1'b0;
		repeat (4) @(negedge clk_i);
		write_strobe_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		wen = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask : wr
	task rd(input logic [2:0] a, output logic [7:0] v);
		@(negedge clk_i);
		host_addr_i = a;
		repeat (3) @(negedge clk_i);
		read_strobe_n_i = 1'b0;
		repeat (6) @(negedge clk_i);
		v = host_data_i;
		read_strobe_n_i = 1'b1;
		repeat (6) @(negedge clk_i);
	endtask : rd
endmodule : hrp_host_model

// *** dv/tb_top.sv ***
// self-checking bench for the host readback port
// assumes the design sources and the checker are compiled before it
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] host_addr_i;
	logic [7:0] host_data_i, host_data_o, v;
	logic write_strobe_n_i, read_strobe_n_i, host_data_oe_n_o, sample_accept_o;
	logic [15:0] i_data_i = 16'h1234, q_data_i = 16'h5678, mag_data_i = 16'h9ABC;
	logic [15:0] phase_data_i = 16'hDEF0, freq_data_i = 16'h2468, timing_err_i = 16'h1357;
	logic [23:0] level_data_i = 24'h321AF5;
	logic [10:0] gain_mant_i = 11'h5A3;
	logic [3:0] gain_shift_i = 4'h9;
	logic [2:0] fifo_depth_i = 3'h5;
	logic fifo_empty_i = 1'b0, fifo_full_i = 1'b1, buffer_ready_n_i = 1'b0;
	logic level_done_a_i = 1'b1, sample_push_i = 1'b0;
	int err_count = 0;
	int cmp_count = 0;
	hrp_host_readback_port dut
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.host_addr_i(host_addr_i),
		.host_data_i(host_data_i),
		.write_strobe_n_i(write_strobe_n_i),
		.read_strobe_n_i(read_strobe_n_i),
		.host_data_o(host_data_o),
		.host_data_oe_n_o(host_data_oe_n_o),
		.i_data_i(i_data_i),
		.q_data_i(q_data_i),
		.mag_data_i(mag_data_i),
		.phase_data_i(phase_data_i),
		.freq_data_i(freq_data_i),
		.level_data_i(level_data_i),
		.gain_mant_i(gain_mant_i),
		.gain_shift_i(gain_shift_i),
		.timing_err_i(timing_err_i),
		.fifo_depth_i(fifo_depth_i),
		.fifo_empty_i(fifo_empty_i),
		.fifo_full_i(fifo_full_i),
		.buffer_ready_n_i(buffer_ready_n_i),
		.level_done_a_i(level_done_a_i),
		.sample_push_i(sample_push_i),
		.sample_accept_o(sample_accept_o)
	);
	hrp_host_model host
	(
		.clk_i(clk_i),
		.host_data_o(host_data_o),
		.host_data_oe_n_o(host_data_oe_n_o),
		.host_addr_i(host_addr_i),
		.host_data_i(host_data_i),
		.write_strobe_n_i(write_strobe_n_i),
		.read_strobe_n_i(read_strobe_n_i)
	);
	initial forever #2.5 clk_i = ~clk_i;
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// gain figures are the ones live when the sampling write was made
	function automatic logic [7:0] ex(input logic [2:0] c, input logic [2:0] a);
		logic [15:0] w;
		case (c)
			3'h0: w = a[1] ? 16'h5678 : 16'h1234;
			3'h1: w = a[1] ? 16'hDEF0 : 16'h9ABC;
			3'h2: w = a[1] ? 16'h0000 : 16'h2468;
			3'h4: w = a[1] ? {8'h00, a[0] ? 8'h00 : 8'h32} : 16'h1AF5;
			3'h5: w = a[1] ? 16'h1357 : {1'b0, 4'h9, 11'h5A3};
			default: w = 16'h0000;
		endcase
		// addresses 4 to 6 are unmapped under every code
		if (a[2])
			w = 16'h0000;
		return a[0] ? w[15:8] : w[7:0];
	endfunction : ex
	initial
	begin
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		host.rd(3'h0, v);
		chk(v, 8'h34);
		host.wr(3'h2, 8'h00);
		gain_mant_i = 11'h0FF;
		gain_shift_i = 4'h2;
		host.wr(3'h4, 8'h01);
		host.rd(3'h1, v);
		chk(v, 8'h12);
		// every code, unused ones too, against every byte address below status
		for (int c = 0; c < 8; c++)
		begin
			host.wr(3'h5, {5'h1F, c[2:0]});
			for (int a = 0; a < 7; a++)
			begin
				host.rd(a[2:0], v);
				chk(v, ex(c[2:0], a[2:0]));
			end
		end
		host.rd(3'h7, v);
		chk(v, 8'h55);
		fifo_depth_i = 3'h2;
		fifo_empty_i = 1'b1;
		fifo_full_i = 1'b0;
		buffer_ready_n_i = 1'b1;
		level_done_a_i = 1'b0;
		host.rd(3'h7, v);
		chk(v, 8'h2A);
		sample_push_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({7'h00, sample_accept_o}, 8'h01);
		fifo_full_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({7'h00, sample_accept_o}, 8'h00);
		chk({7'h00, host_data_oe_n_o}, 8'h01);
		// mid-run reset: read code falls back to 000, gain sample is cleared
		rst_i = 1'b1;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		chk({7'h00, host_data_oe_n_o}, 8'h01);
		host.rd(3'h0, v);
		chk(v, 8'h34);
		host.wr(3'h5, 8'h05);
		host.rd(3'h1, v);
		chk(v, 8'h00);
		host.rd(3'h3, v);
		chk(v, 8'h13);
		wrap_up();
	end
	initial
	begin
		#50000;
		err_count++;
		wrap_up();
	end
endmodule : tb_top
bind hrp_host_readback_port hrp_checker chk_i
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.host_addr_i(host_addr_i),
	.read_strobe_n_i(read_strobe_n_i),
	.host_data_o(host_data_o),
	.host_data_oe_n_o(host_data_oe_n_o),
	.fifo_depth_i(fifo_depth_i),
	.fifo_empty_i(fifo_empty_i),
	.fifo_full_i(fifo_full_i),
	.buffer_ready_n_i(buffer_ready_n_i),
	.level_done_a_i(level_done_a_i),
	.sample_push_i(sample_push_i),
	.sample_accept_o(sample_accept_o)
);
